//--- src/apfs_pkg.sv
package apfs_pkg;
	// Pin group widths
	localparam int UPPER_W = 4;
	localparam int LOWER_W = 16;
	localparam int HOST_DATA_W = 16;
	// Values taken while reset is asserted and right after release
	localparam logic [3:0] UPPER_RESET_VAL = 4'h0;
	localparam logic [15:0] LOWER_RESET_VAL = 16'h0000;
	localparam logic HOLDER_RESET_EN = 1'b1;
	localparam logic STRAP_RESET_VAL = 1'b0;
	// Number of synchroniser stages on pin inputs
	localparam int SYNC_STAGES = 2;

	// Strap capture state: capturing or locked
	typedef enum logic [1:0] {
		APFS_MODE_RESET = 2'b01,
		APFS_MODE_LOCKED = 2'b10
	} apfs_lock_t;
endpackage

//--- src/apfs_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a pin bus
module apfs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= i_d;
			sync_reg <= meta_reg;
		end
	end

	assign o_q = sync_reg;
endmodule

//--- src/apfs_holder.sv
`timescale 1ns/1ps
// Bus holder model: remembers the level last driven on each pin
module apfs_holder #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Pin drive state
	input wire logic [W-1:0] i_drive_val,
	input wire logic [W-1:0] i_drive_oe,
	input wire logic i_hold_en,
	// Held level
	output logic [W-1:0] o_hold_val,
	output logic [W-1:0] o_hold_oe
);
	logic [W-1:0] last_reg;
	logic [W-1:0] oe_reg;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			last_reg <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (i_drive_oe[i]) begin
					last_reg[i] <= i_drive_val[i];
				end
			end
		end
	end

	// Weak keeper only acts on pins nobody drives
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			oe_reg <= '0;
		end else begin
			oe_reg <= ~i_drive_oe & {W{i_hold_en}};
		end
	end

	assign o_hold_val = last_reg;
	assign o_hold_oe = oe_reg;
endmodule

//--- src/apfs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Strap low puts the upper four pins on parallel io bits 3..0, high on ext mem addr 21..18.
// - Strap low puts the lower sixteen pins on host address 15..0, high on ext mem addr 17..2.
// - The function is latched on reset release and held until the next reset.
// - Undriven address pins are kept by bus holders at their last driven level.
// - Holders are enabled at reset and later follow the external bus control bit.
// - In parallel io mode bits 3..0 are inputs after reset.
// - In ext mem mode addr 21..18 float during reset then drive zero.
// - In ext mem mode addr 17..2 float during reset then drive zero.
// - In host mode the host address pins are inputs after reset.
// - Strap low selects the non-multiplexed host port.
// - Non-multiplexed host mode uses a 16-bit address and a separate 16-bit data bus.
// - Each host cycle moves exactly one 16-bit word.
module apfs_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Strap pin
	input wire logic i_function_strap_pin,
	// Holder control from the external bus control register
	input wire logic i_external_bus_control_reg_hold_en,
	// Core side: external memory interface address
	input wire logic [3:0] i_ext_mem_addr_upper,
	input wire logic [15:0] i_ext_mem_addr_lower,
	// Core side: parallel io low bits
	input wire logic [3:0] i_parallel_io_low_bits_out,
	input wire logic [3:0] i_parallel_io_low_bits_dir,
	output logic [3:0] o_parallel_io_low_bits_in,
	// Core side: host port address and mode
	output logic [15:0] o_host_port_address,
	output logic o_host_port_non_mux,
	output logic o_ext_mem_mode,
	// Upper address pins
	input wire logic [3:0] i_pin_upper,
	output logic [3:0] o_pin_upper,
	output logic [3:0] o_pin_upper_oe,
	output logic [3:0] o_pin_upper_hold,
	output logic [3:0] o_pin_upper_hold_oe,
	// Lower address pins
	input wire logic [15:0] i_pin_lower,
	output logic [15:0] o_pin_lower,
	output logic [15:0] o_pin_lower_oe,
	output logic [15:0] o_pin_lower_hold,
	output logic [15:0] o_pin_lower_hold_oe
);
	logic strap_s;
	logic hold_en_s;
	logic [3:0] pin_upper_s;
	logic [15:0] pin_lower_s;
	logic ext_mem_reg;
	logic in_reset_reg;
	apfs_pkg::apfs_lock_t lock_reg;
	logic hold_en_reg;
	logic [3:0] upper_val_reg;
	logic [3:0] upper_oe_reg;
	logic [15:0] lower_val_reg;
	logic [15:0] lower_oe_reg;
	logic [3:0] pio_in_reg;
	logic [15:0] host_addr_reg;
	logic [3:0] upper_hold_val;
	logic [3:0] upper_hold_oe;
	logic [15:0] lower_hold_val;
	logic [15:0] lower_hold_oe;
	// Syncs for strap and holder enable
	logic strap_meta_reg;
	logic strap_sync_reg;
	logic hold_meta_reg;
	logic hold_sync_reg;
	logic non_mux_reg;
	// Shared selector results, sixteen bits for both groups
	logic [15:0] upper_val_wide;
	logic [15:0] upper_oe_wide;
	logic [15:0] lower_val_wide;
	logic [15:0] lower_oe_wide;
	logic [15:0] upper_in_wide;
	logic [15:0] lower_in_wide;

	// Lock state test shared by the release and holder logic
	function automatic logic is_locked(
		input apfs_pkg::apfs_lock_t state
	);
		is_locked = (state == apfs_pkg::APFS_MODE_LOCKED);
	endfunction

	// Drive enable of one pin group
	function automatic logic [15:0] group_oe(
		input logic released,
		input logic mem_owned,
		input logic [15:0] core_dir
	);
		if (released) begin
			group_oe = 16'h0000;
		end else if (mem_owned) begin
			group_oe = 16'hffff;
		end else begin
			group_oe = core_dir;
		end
	endfunction

	// Drive value of one pin group, reset level while released
	function automatic logic [15:0] group_val(
		input logic released,
		input logic mem_owned,
		input logic [15:0] mem_addr,
		input logic [15:0] io_out,
		input logic [15:0] rst_val
	);
		if (released) begin
			group_val = rst_val;
		end else if (mem_owned) begin
			group_val = mem_addr;
		end else begin
			group_val = io_out;
		end
	endfunction

	// Core sees zero on pins the memory interface owns
	function automatic logic [15:0] core_view(
		input logic mem_owned,
		input logic [15:0] pin_lvl
	);
		core_view = mem_owned ? 16'h0000 : pin_lvl;
	endfunction

	// Pin inputs pass two flops first.
	// Strap sync has no reset: it keeps sampling while reset is low,
	// so the strap level is already settled when reset lifts.
	always_ff @(posedge i_clk) begin
		strap_meta_reg <= i_function_strap_pin;
		strap_sync_reg <= strap_meta_reg;
	end

	// A reset sync here would switch holders off for a cycle after release
	always_ff @(posedge i_clk) begin
		hold_meta_reg <= i_external_bus_control_reg_hold_en;
		hold_sync_reg <= hold_meta_reg;
	end

	assign strap_s = strap_sync_reg;
	assign hold_en_s = hold_sync_reg;

	apfs_sync #(.W(apfs_pkg::UPPER_W)) u_sync_upper (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d(i_pin_upper),
		.o_q(pin_upper_s)
	);

	apfs_sync #(.W(apfs_pkg::LOWER_W)) u_sync_lower (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d(i_pin_lower),
		.o_q(pin_lower_s)
	);

	// Strap is caught on the first edge after release, then frozen.
	// Relies on the board keeping it steady across the release.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lock_reg <= apfs_pkg::APFS_MODE_RESET;
		end else begin
			case (lock_reg)
				apfs_pkg::APFS_MODE_RESET: begin
					lock_reg <= apfs_pkg::APFS_MODE_LOCKED;
				end
				apfs_pkg::APFS_MODE_LOCKED: begin
					lock_reg <= apfs_pkg::APFS_MODE_LOCKED;
				end
				default: begin
					lock_reg <= apfs_pkg::APFS_MODE_RESET;
				end
			endcase
		end
	end

	// Function flags, written only in the capture state
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ext_mem_reg <= apfs_pkg::STRAP_RESET_VAL;
			non_mux_reg <= !apfs_pkg::STRAP_RESET_VAL;
		end else if (lock_reg == apfs_pkg::APFS_MODE_RESET) begin
			ext_mem_reg <= strap_s;
			non_mux_reg <= !strap_s;
		end
	end

	// Pins stay released until the function is known.
	// One extra edge so no pin ever sees a half-captured mode.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			in_reset_reg <= 1'b1;
		end else begin
			in_reset_reg <= !is_locked(lock_reg);
		end
	end

	// Holders on from reset, then software-controlled
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hold_en_reg <= apfs_pkg::HOLDER_RESET_EN;
		end else if (is_locked(lock_reg)) begin
			hold_en_reg <= hold_en_s;
		end
	end

	// One selector for both groups; the upper group pays with zero padding
	assign upper_oe_wide = group_oe(in_reset_reg, ext_mem_reg,
		{12'h000, i_parallel_io_low_bits_dir});
	assign upper_val_wide = group_val(in_reset_reg, ext_mem_reg,
		{12'h000, i_ext_mem_addr_upper}, {12'h000, i_parallel_io_low_bits_out},
		{12'h000, apfs_pkg::UPPER_RESET_VAL});
	// Host mode never drives the lower group
	assign lower_oe_wide = group_oe(in_reset_reg, ext_mem_reg, 16'h0000);
	assign lower_val_wide = group_val(in_reset_reg, ext_mem_reg, i_ext_mem_addr_lower,
		apfs_pkg::LOWER_RESET_VAL, apfs_pkg::LOWER_RESET_VAL);

	// Upper pin drive
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			upper_val_reg <= apfs_pkg::UPPER_RESET_VAL;
			upper_oe_reg <= '0;
		end else begin
			upper_val_reg <= upper_val_wide[3:0];
			upper_oe_reg <= upper_oe_wide[3:0];
		end
	end

	// Lower pin drive; host mode never drives them
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lower_val_reg <= apfs_pkg::LOWER_RESET_VAL;
			lower_oe_reg <= '0;
		end else begin
			lower_val_reg <= lower_val_wide;
			lower_oe_reg <= lower_oe_wide;
		end
	end

	assign upper_in_wide = core_view(ext_mem_reg, {12'h000, pin_upper_s});
	assign lower_in_wide = core_view(ext_mem_reg, pin_lower_s);

	// Parallel io input path back to the core
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pio_in_reg <= '0;
		end else begin
			pio_in_reg <= upper_in_wide[3:0];
		end
	end

	// Host address input path back to the core
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			host_addr_reg <= '0;
		end else begin
			host_addr_reg <= lower_in_wide;
		end
	end

	apfs_holder #(.W(apfs_pkg::UPPER_W)) u_hold_upper (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_drive_val(upper_val_reg),
		.i_drive_oe(upper_oe_reg),
		.i_hold_en(hold_en_reg),
		.o_hold_val(upper_hold_val),
		.o_hold_oe(upper_hold_oe)
	);

	apfs_holder #(.W(apfs_pkg::LOWER_W)) u_hold_lower (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_drive_val(lower_val_reg),
		.i_drive_oe(lower_oe_reg),
		.i_hold_en(hold_en_reg),
		.o_hold_val(lower_hold_val),
		.o_hold_oe(lower_hold_oe)
	);

	// Non-multiplexed host port, one 16-bit word per cycle
	assign o_host_port_non_mux = non_mux_reg;
	assign o_ext_mem_mode = ext_mem_reg;
	assign o_parallel_io_low_bits_in = pio_in_reg;
	assign o_host_port_address = host_addr_reg;
	assign o_pin_upper = upper_val_reg;
	assign o_pin_upper_oe = upper_oe_reg;
	assign o_pin_lower = lower_val_reg;
	assign o_pin_lower_oe = lower_oe_reg;
	// Keeper drives last level on floating pins.
	assign o_pin_upper_hold = upper_hold_val;
	assign o_pin_upper_hold_oe = upper_hold_oe;
	assign o_pin_lower_hold = lower_hold_val;
	assign o_pin_lower_hold_oe = lower_hold_oe;
endmodule

//--- dv/apfs_asserts.sv
`timescale 1ns/1ps
module apfs_asserts (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_external_bus_control_reg_hold_en,
	input wire logic [3:0] i_ext_mem_addr_upper,
	input wire logic [3:0] i_parallel_io_low_bits_dir,
	input wire logic [15:0] i_pin_lower,
	input wire logic [15:0] o_host_port_address,
	input wire logic o_host_port_non_mux,
	input wire logic o_ext_mem_mode,
	input wire logic [3:0] o_pin_upper,
	input wire logic [3:0] o_pin_upper_oe,
	input wire logic [15:0] o_pin_lower,
	input wire logic [15:0] o_pin_lower_oe,
	input wire logic [15:0] o_pin_lower_hold,
	input wire logic [15:0] o_pin_lower_hold_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Early cycles after release still carry reset values
	logic [2:0] age_reg;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) age_reg <= 3'h0;
		else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
	end
	wire ready = (age_reg == 3'h7);
	wire em = o_ext_mem_mode;
	property p_up; ready && em |-> o_pin_upper == $past(i_ext_mem_addr_upper); endproperty
	a_up: assert property (p_up) else $error("upper drive");
	property p_ext_oe; ready && em |-> o_pin_upper_oe == 4'hf && o_pin_lower_oe == 16'hffff;
	endproperty
	a_ext_oe: assert property (p_ext_oe) else $error("ext oe");
	property p_quiet; ready && em |-> o_host_port_address == 16'h0; endproperty
	a_quiet: assert property (p_quiet) else $error("host addr");
	property p_dir; ready && !em |-> o_pin_upper_oe == $past(i_parallel_io_low_bits_dir);
	endproperty
	a_dir: assert property (p_dir) else $error("io dir");
	property p_host; ready && !em |-> o_pin_lower_oe == 16'h0 &&
		o_host_port_address == $past(i_pin_lower, 3); endproperty
	a_host: assert property (p_host) else $error("host in");
	property p_nm; o_host_port_non_mux == !em; endproperty
	a_nm: assert property (p_nm) else $error("non mux");
	property p_lock; ready |-> $stable(em); endproperty
	a_lock: assert property (p_lock) else $error("mode moved");
	property p_keep; ready && $past(o_pin_lower_oe) == 16'hffff |->
		o_pin_lower_hold == $past(o_pin_lower); endproperty
	a_keep: assert property (p_keep) else $error("keeper");
	property p_hen; i_external_bus_control_reg_hold_en [*5] ##0 (ready && !em) |->
		o_pin_lower_hold_oe == 16'hffff; endproperty
	a_hen: assert property (p_hen) else $error("keeper off");
	c_ext: cover property (ready && em);
	c_host: cover property (ready && !em);
	c_dir: cover property (ready && !em && o_pin_upper_oe == 4'hf);
endmodule

bind apfs_top apfs_asserts u_chk (.*);

//--- dv/apfs_partner.sv
`timescale 1ns/1ps
// Far side of one address pin group: host, memory or nothing
module apfs_partner #(
	parameter int W = 4
) (
	input wire logic i_clk,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_val,
	input wire logic [W-1:0] i_hold,
	input wire logic [W-1:0] i_hold_oe,
	input wire logic [W-1:0] i_ext_en,
	input wire logic [W-1:0] i_ext_val,
	output logic [W-1:0] o_lvl
);
	// Floating wire wanders so a missing keeper shows
	logic [W-1:0] drift = '0;
	always @(posedge i_clk) drift <= ~drift;
	// Keeper is weak: any real driver wins over it
	assign o_lvl = (i_oe & i_val) | (~i_oe & i_ext_en & i_ext_val)
		| (~i_oe & ~i_ext_en & ((i_hold_oe & i_hold) | (~i_hold_oe & drift)));
endmodule

//--- dv/address_pin_function_select_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, a); end end
module address_pin_function_select_bench;
	logic clk = 0, rstn = 0, strap = 0, hen = 1, xen = 0, nm, mm;
	logic [3:0] au = 0, dir = 0, iout = 0, xu = 0, pu, ou, oeu, hu, hou, inu;
	logic [15:0] al = 0, xl = 0, pl, ol, oel, hl, hol, ha;
	logic [24:0] r;
	logic [24:0] rows [4] = '{25'h1ffff0, 25'h1800010, 25'h05a5a5f, 25'h0380010};
	int errors = 0, total_checks = 0;
	initial forever #5 clk = ~clk;
	apfs_top u_dut (.i_clk(clk), .i_rstn(rstn), .i_function_strap_pin(strap),
		.i_external_bus_control_reg_hold_en(hen), .i_ext_mem_addr_upper(au),
		.i_ext_mem_addr_lower(al), .i_parallel_io_low_bits_out(iout),
		.i_parallel_io_low_bits_dir(dir), .o_parallel_io_low_bits_in(inu),
		.o_host_port_address(ha), .o_host_port_non_mux(nm), .o_ext_mem_mode(mm),
		.i_pin_upper(pu), .o_pin_upper(ou), .o_pin_upper_oe(oeu), .o_pin_upper_hold(hu),
		.o_pin_upper_hold_oe(hou), .i_pin_lower(pl), .o_pin_lower(ol),
		.o_pin_lower_oe(oel), .o_pin_lower_hold(hl), .o_pin_lower_hold_oe(hol));
	apfs_partner #(.W(4)) u_pu (.i_clk(clk), .i_oe(oeu), .i_val(ou), .i_hold(hu),
		.i_hold_oe(hou), .i_ext_en({4{xen}}), .i_ext_val(xu), .o_lvl(pu));
	apfs_partner #(.W(16)) u_pl (.i_clk(clk), .i_oe(oel), .i_val(ol), .i_hold(hl),
		.i_hold_oe(hol), .i_ext_en({16{xen}}), .i_ext_val(xl), .o_lvl(pl));
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Strap stays put from reset entry through release
	task automatic reset_to(input logic s);
		@(negedge clk);
		rstn = 0;
		strap = s;
		repeat (16) @(negedge clk);
		`CHK("reset oe", 20'h0, {oeu, oel})
		`CHK("reset non mux", 1'b1, nm)
		rstn = 1;
		repeat (8) @(negedge clk);
	endtask
	initial begin
		#20000;
		errors++;
		report_and_stop;
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			r = rows[i];
			{au, iout, xu} = {3{r[23:20]}};
			{al, xl} = {2{r[19:4]}};
			dir = r[3:0];
			xen = !r[24];
			reset_to(r[24]);
			`CHK("mode", r[24], mm)
			`CHK("non mux", !r[24], nm)
			if (r[24]) begin
				`CHK("upper", r[23:20], ou)
				`CHK("lower", r[19:4], ol)
				`CHK("oe", 20'hfffff, {oeu, oel})
				`CHK("io in masked", 4'h0, inu)
				`CHK("host addr masked", 16'h0, ha)
			end else begin
				`CHK("host addr", r[19:4], ha)
				`CHK("lower oe", 16'h0, oel)
				`CHK("upper oe", r[3:0], oeu)
				`CHK("io in", r[23:20], inu)
			end
			$display("row %0d done", i);
		end
		strap = 1;
		repeat (8) @(negedge clk);
		`CHK("locked", 1'b0, mm)
		$display("lock test done");
		xen = 0;
		dir = 4'hf;
		iout = 4'h9;
		repeat (4) @(negedge clk);
		dir = 4'h0;
		repeat (4) @(negedge clk);
		`CHK("kept", 4'h9, pu)
		`CHK("keep oe", 4'hf, hou)
		hen = 0;
		repeat (6) @(negedge clk);
		`CHK("keep off", 4'h0, hou)
		$display("keeper test done");
		report_and_stop;
	end
endmodule
